// File: inc/pmcx_pkg.sv
package pmcx_pkg;
  // ********************************
  // Register offsets (byte address)
  // ********************************
  localparam logic [7:0] PMCX_OFS_SCON = 8'h00;
  localparam logic [7:0] PMCX_OFS_SCOFF = 8'h04;
  localparam logic [7:0] PMCX_OFS_SCSTATE = 8'h08;
  localparam logic [7:0] PMCX_OFS_OSC = 8'h20;
  localparam logic [7:0] PMCX_OFS_FREQ = 8'h24;
  localparam logic [7:0] PMCX_OFS_PLL = 8'h2C;
  localparam logic [7:0] PMCX_OFS_MCK = 8'h30;
  localparam logic [7:0] PMCX_OFS_PCK0 = 8'h40;
  localparam logic [7:0] PMCX_OFS_SR = 8'h68;
  // ********************************
  // Field positions
  // ********************************
  localparam int PMCX_SC_PCK_LSB = 8;
  localparam int PMCX_OSC_ON_BIT = 0;
  localparam int PMCX_OSC_CNT_LSB = 8;
  localparam int PMCX_MEAS_DONE_BIT = 16;
  localparam int PMCX_PLL_DIV_LSB = 0;
  localparam int PMCX_PLL_CNT_LSB = 8;
  localparam int PMCX_PLL_RNG_LSB = 14;
  localparam int PMCX_PLL_MUL_LSB = 16;
  localparam int PMCX_CSS_LSB = 0;
  localparam int PMCX_POWER_OF_TWO_RATIO_LSB = 2;
  localparam int PMCX_SR_STABLE_BIT = 0;
  localparam int PMCX_SR_LOCK_BIT = 2;
  localparam int PMCX_SR_MASTER_CLOCK_SETTLED_BIT = 3;
  localparam int PMCX_SR_PCKRDY_LSB = 8;
  // ********************************
  // Reset values and counts
  // ********************************
  localparam logic [31:0] PMCX_PLL_RST = 32'h0000_3F00;
  localparam logic [31:0] PMCX_OSC_RST = 32'h0000_0000;
  localparam logic [4:0] PMCX_CFG_RST = 5'h00;
  localparam int PMCX_STARTUP_SHIFT = 3;
  localparam logic [3:0] PMCX_MEAS_LAST_FALL = 4'hF;
  localparam logic [2:0] PMCX_POWER_OF_TWO_RATIO_MAX = 3'h6;
  // ********************************
  // Clock sources and measurement states
  // ********************************
  localparam logic [1:0] PMCX_SRC_SLOW = 2'h0;
  localparam logic [1:0] PMCX_SRC_MAIN = 2'h1;
  localparam logic [1:0] PMCX_SRC_PLL = 2'h3;
  typedef enum logic [3:0] {
    PMCX_M_IDLE = 4'h1,
    PMCX_M_ARM = 4'h2,
    PMCX_M_RUN = 4'h4,
    PMCX_M_DONE = 4'h8
  } pmcx_meas_t;
endpackage

// File: inc/pmcx_div_if.sv
`timescale 1ns/100ps
interface pmcx_div_if;
  logic [1:0] sel;
  logic [2:0] ratio;
  logic run;
  logic restart;
  logic clk_out;
  logic settled;
  modport ctrl (output sel, output ratio, output run, output restart,
    input clk_out, input settled);
  modport gen (input sel, input ratio, input run, input restart,
    output clk_out, output settled);
endinterface

// File: design/pmcx_prescaler.sv
`timescale 1ns/100ps
module pmcx_prescaler #(
  parameter int CW = 6
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] src_level,
  input wire logic [3:0] src_rise,
  pmcx_div_if.gen div
);
  logic [CW-1:0] cnt;
  wire tick = src_rise[div.sel];
  wire lvl = src_level[div.sel];
  // Reserved ratio code acts as the largest one
  wire [2:0] r = (div.ratio > pmcx_pkg::PMCX_POWER_OF_TWO_RATIO_MAX) ?
    pmcx_pkg::PMCX_POWER_OF_TWO_RATIO_MAX : div.ratio;
  wire [CW-1:0] half_m1 = (r == 3'h0) ? {CW{1'b0}} :
    (CW'(1) << (r - 3'h1)) - CW'(1);
  wire wrap = tick & (cnt == half_m1);
  wire out_rise = (r == 3'h0) ? (lvl & ~div.clk_out) : (wrap & ~div.clk_out);
  // Toggle divider; a restart drops the output at once, so glitches are possible
  always_ff @(posedge clk_sys) begin
    if (sys_rst | div.restart | ~div.run) begin
      cnt <= {CW{1'b0}};
      div.clk_out <= 1'b0;
      div.settled <= 1'b0;
    end else begin
      div.settled <= div.settled | out_rise;
      if (r == 3'h0) begin
        div.clk_out <= lvl;
      end else if (wrap) begin
        cnt <= {CW{1'b0}};
        div.clk_out <= ~div.clk_out;
      end else if (tick) begin
        cnt <= cnt + CW'(1);
      end
    end
  end
endmodule

// File: design/pmcx_top.sv
`timescale 1ns/100ps
module pmcx_top #(
  parameter int NOUT = 3,
  parameter int TALLY_W = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic slow_clock,
  input wire logic main_clock,
  input wire logic pll_clock,
  output logic [NOUT-1:0] prog_clock_out,
  output logic master_clk_out,
  output logic osc_enable,
  output logic [7:0] pll_divider,
  output logic [10:0] pll_factor,
  output logic [1:0] pll_range,
  output logic pll_enable
);
  // ********************************
  // Wishbone slave
  // ********************************
  logic [NOUT-1:0] pck_on;
  logic [NOUT-1:0] pck_settled;
  logic [4:0] pck_cfg [NOUT];
  logic [7:0] startup_count;
  logic [5:0] lock_wait_count;
  logic [1:0] mck_css;
  logic [2:0] mck_power_of_two_ratio;
  logic osc_stable;
  logic pll_lock;
  logic master_settled;
  logic [TALLY_W-1:0] osc_cycle_tally;
  pmcx_pkg::pmcx_meas_t meas_state;
  pmcx_pkg::pmcx_meas_t next_meas_state;

  // Decode on word index; every access is acknowledged
  wire req = wb_cyc_i & wb_stb_i;
  wire wr_fire = req & wb_we_i & wb_ack_o;
  wire [5:0] widx = wb_adr_i[7:2];
  wire hit_scon = widx == pmcx_pkg::PMCX_OFS_SCON[7:2];
  wire hit_scoff = widx == pmcx_pkg::PMCX_OFS_SCOFF[7:2];
  wire hit_scst = widx == pmcx_pkg::PMCX_OFS_SCSTATE[7:2];
  wire hit_osc = widx == pmcx_pkg::PMCX_OFS_OSC[7:2];
  wire hit_freq = widx == pmcx_pkg::PMCX_OFS_FREQ[7:2];
  wire hit_pll = widx == pmcx_pkg::PMCX_OFS_PLL[7:2];
  wire hit_mck = widx == pmcx_pkg::PMCX_OFS_MCK[7:2];
  wire hit_sr = widx == pmcx_pkg::PMCX_OFS_SR[7:2];
  wire [31:0] lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wmask = wb_dat_i & lane;

  // Byte-lane merge for read/write registers
  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~lane) | wmask;
  endfunction

  // Current register images
  wire [31:0] osc_word = 32'(osc_enable) | (32'(startup_count) << pmcx_pkg::PMCX_OSC_CNT_LSB);
  wire [31:0] pll_word = (32'(pll_divider) << pmcx_pkg::PMCX_PLL_DIV_LSB)
    | (32'(lock_wait_count) << pmcx_pkg::PMCX_PLL_CNT_LSB)
    | (32'(pll_range) << pmcx_pkg::PMCX_PLL_RNG_LSB)
    | (32'(pll_factor) << pmcx_pkg::PMCX_PLL_MUL_LSB);
  wire [31:0] mck_word = (32'(mck_css) << pmcx_pkg::PMCX_CSS_LSB)
    | (32'(mck_power_of_two_ratio) << pmcx_pkg::PMCX_POWER_OF_TWO_RATIO_LSB);
  wire [31:0] sc_word = 32'(pck_on) << pmcx_pkg::PMCX_SC_PCK_LSB;
  wire meas_done = meas_state == pmcx_pkg::PMCX_M_DONE;
  wire [31:0] freq_word = 32'(osc_cycle_tally)
    | (32'(meas_done) << pmcx_pkg::PMCX_MEAS_DONE_BIT);
  wire [31:0] sr_word = (32'(osc_stable) << pmcx_pkg::PMCX_SR_STABLE_BIT)
    | (32'(pll_lock) << pmcx_pkg::PMCX_SR_LOCK_BIT)
    | (32'(master_settled) << pmcx_pkg::PMCX_SR_MASTER_CLOCK_SETTLED_BIT)
    | (32'(pck_settled) << pmcx_pkg::PMCX_SR_PCKRDY_LSB);
  wire [31:0] osc_new = merge(osc_word);
  wire [31:0] pll_new = merge(pll_word);
  wire [31:0] mck_new = merge(mck_word);

  // Output-clock config words and their decode
  logic [NOUT-1:0] hit_pck;
  logic [31:0] pck_rd [NOUT+1];
  assign pck_rd[0] = 32'h0000_0000;
  for (genvar i = 0; i < NOUT; i++) begin : g_pdec
    assign hit_pck[i] = widx == 6'(pmcx_pkg::PMCX_OFS_PCK0[7:2] + 6'(i));
    assign pck_rd[i+1] = pck_rd[i] | (hit_pck[i] ? 32'(pck_cfg[i]) : 32'h0000_0000);
  end

  // Read selection; write-only and unmapped words read zero
  wire [31:0] rd_word = hit_scst ? sc_word :
    hit_osc ? osc_word :
    hit_freq ? freq_word :
    hit_pll ? pll_word :
    hit_mck ? mck_word :
    hit_sr ? sr_word :
    pck_rd[NOUT];

  // Registered ack, one cycle, data valid with it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= (req & ~wb_ack_o & ~wb_we_i) ? rd_word : 32'h0000_0000;
    end
  end

  // ********************************
  // Source clock edge detection
  // ********************************
  logic [2:0] src_q;
  // No reset: a pin high at release must not fake a rising edge
  always_ff @(posedge clk_sys) begin
    src_q <= {pll_clock, main_clock, slow_clock};
  end
  // Sources are sampled, so each must stay below half of clk_sys
  wire slow_rise = slow_clock & ~src_q[0];
  wire slow_fall = ~slow_clock & src_q[0];
  wire main_rise = main_clock & ~src_q[1];
  wire [3:0] src_level = {pll_clock, 1'b0, main_clock, slow_clock};
  wire [3:0] src_rise = {pll_clock & ~src_q[2], 1'b0, main_rise, slow_rise};

  // ********************************
  // Main oscillator start-up
  // ********************************
  logic [10:0] osc_cnt;
  wire osc_wr = wr_fire & hit_osc;
  wire osc_start = osc_wr & osc_new[pmcx_pkg::PMCX_OSC_ON_BIT] & ~osc_enable;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      osc_enable <= pmcx_pkg::PMCX_OSC_RST[pmcx_pkg::PMCX_OSC_ON_BIT];
      startup_count <= pmcx_pkg::PMCX_OSC_RST[pmcx_pkg::PMCX_OSC_CNT_LSB +: 8];
    end else if (osc_wr) begin
      osc_enable <= osc_new[pmcx_pkg::PMCX_OSC_ON_BIT];
      startup_count <= osc_new[pmcx_pkg::PMCX_OSC_CNT_LSB +: 8];
    end
  end

  // Count 8 slow rises per unit, then flag stable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      osc_cnt <= 11'h000;
      osc_stable <= 1'b0;
    end else if (osc_start) begin
      osc_cnt <= 11'(osc_new[pmcx_pkg::PMCX_OSC_CNT_LSB +: 8])
        << pmcx_pkg::PMCX_STARTUP_SHIFT;
      osc_stable <= 1'b0;
    end else if (~osc_enable) begin
      osc_cnt <= 11'h000;
      osc_stable <= 1'b0;
    end else if (osc_cnt != 11'h000) begin
      osc_cnt <= slow_rise ? osc_cnt - 11'h001 : osc_cnt;
    end else begin
      osc_stable <= 1'b1;
    end
  end

  // ********************************
  // Main clock frequency measurement
  // ********************************
  logic [3:0] fall_cnt;
  // Arm on stable, open at next slow rise, close at 16th fall
  always_comb begin
    next_meas_state = meas_state;
    case (meas_state)
      pmcx_pkg::PMCX_M_IDLE: begin
        if (osc_stable) next_meas_state = pmcx_pkg::PMCX_M_ARM;
      end
      pmcx_pkg::PMCX_M_ARM: begin
        if (slow_rise) next_meas_state = pmcx_pkg::PMCX_M_RUN;
      end
      pmcx_pkg::PMCX_M_RUN: begin
        if (slow_fall && fall_cnt == pmcx_pkg::PMCX_MEAS_LAST_FALL) begin
          next_meas_state = pmcx_pkg::PMCX_M_DONE;
        end
      end
      pmcx_pkg::PMCX_M_DONE: begin
        next_meas_state = pmcx_pkg::PMCX_M_DONE;
      end
      default: begin
        next_meas_state = pmcx_pkg::PMCX_M_IDLE;
      end
    endcase
    if (!osc_stable) next_meas_state = pmcx_pkg::PMCX_M_IDLE;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meas_state <= pmcx_pkg::PMCX_M_IDLE;
    end else begin
      meas_state <= next_meas_state;
    end
  end

  // Tally main rises while the window is open
  always_ff @(posedge clk_sys) begin
    if (sys_rst || meas_state == pmcx_pkg::PMCX_M_ARM) begin
      osc_cycle_tally <= {TALLY_W{1'b0}};
      fall_cnt <= 4'h0;
    end else if (meas_state == pmcx_pkg::PMCX_M_RUN) begin
      osc_cycle_tally <= main_rise ? osc_cycle_tally + TALLY_W'(1) : osc_cycle_tally;
      fall_cnt <= slow_fall ? fall_cnt + 4'h1 : fall_cnt;
    end
  end

  // ********************************
  // PLL configuration and lock
  // ********************************
  logic [5:0] lock_cnt;
  logic lock_pending;
  wire pll_wr = wr_fire & hit_pll;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pll_divider <= pmcx_pkg::PMCX_PLL_RST[pmcx_pkg::PMCX_PLL_DIV_LSB +: 8];
      lock_wait_count <= pmcx_pkg::PMCX_PLL_RST[pmcx_pkg::PMCX_PLL_CNT_LSB +: 6];
      pll_range <= pmcx_pkg::PMCX_PLL_RST[pmcx_pkg::PMCX_PLL_RNG_LSB +: 2];
      pll_factor <= pmcx_pkg::PMCX_PLL_RST[pmcx_pkg::PMCX_PLL_MUL_LSB +: 11];
      pll_enable <= 1'b0;
    end else begin
      if (pll_wr) begin
        pll_divider <= pll_new[pmcx_pkg::PMCX_PLL_DIV_LSB +: 8];
        lock_wait_count <= pll_new[pmcx_pkg::PMCX_PLL_CNT_LSB +: 6];
        pll_range <= pll_new[pmcx_pkg::PMCX_PLL_RNG_LSB +: 2];
        pll_factor <= pll_new[pmcx_pkg::PMCX_PLL_MUL_LSB +: 11];
      end
      // Zero divider or zero factor stops the analog loop
      pll_enable <= (pll_divider != 8'h00) && (pll_factor != 11'h000);
    end
  end

  // Any write reloads the wait; lock drops at once
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lock_cnt <= 6'h00;
      lock_pending <= 1'b0;
      pll_lock <= 1'b0;
    end else if (pll_wr) begin
      lock_cnt <= pll_new[pmcx_pkg::PMCX_PLL_CNT_LSB +: 6];
      lock_pending <= 1'b1;
      pll_lock <= 1'b0;
    end else if (lock_pending) begin
      if (lock_cnt == 6'h00) begin
        lock_pending <= 1'b0;
        pll_lock <= 1'b1;
      end else if (slow_rise) begin
        lock_cnt <= lock_cnt - 6'h01;
      end
    end
  end

  // ********************************
  // Divider channels
  // ********************************
  pmcx_div_if div_if [NOUT+1] ();
  logic [1:0] mck_sel_q;
  // While the PLL is selected but unlocked the master runs from main
  wire pll_hold = (mck_css == pmcx_pkg::PMCX_SRC_PLL) & ~pll_lock;
  wire [1:0] mck_sel = pll_hold ? pmcx_pkg::PMCX_SRC_MAIN : mck_css;
  wire mck_wr = wr_fire & hit_mck;
  wire mck_restart = mck_wr | (mck_sel != mck_sel_q);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mck_css <= pmcx_pkg::PMCX_SRC_SLOW;
      mck_power_of_two_ratio <= 3'h0;
      mck_sel_q <= pmcx_pkg::PMCX_SRC_SLOW;
      master_settled <= 1'b0;
    end else begin
      if (mck_wr) begin
        mck_css <= mck_new[pmcx_pkg::PMCX_CSS_LSB +: 2];
        mck_power_of_two_ratio <= mck_new[pmcx_pkg::PMCX_POWER_OF_TWO_RATIO_LSB +: 3];
      end
      mck_sel_q <= mck_sel;
      // Ready only once the new clock has produced a rising edge
      master_settled <= div_if[NOUT].settled & ~pll_hold & ~mck_restart;
    end
  end

  // Master channel sits past the output channels
  assign div_if[NOUT].sel = mck_sel;
  assign div_if[NOUT].ratio = mck_power_of_two_ratio;
  assign div_if[NOUT].run = 1'b1;
  assign div_if[NOUT].restart = mck_restart;
  assign master_clk_out = div_if[NOUT].clk_out;

  pmcx_prescaler #(.CW(6)) u_mck_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .src_level(src_level),
    .src_rise(src_rise),
    .div(div_if[NOUT])
  );

  // On/off strobes; disable wins if both ever meet
  wire [NOUT-1:0] on_bits = (wr_fire & hit_scon) ?
    wmask[pmcx_pkg::PMCX_SC_PCK_LSB +: NOUT] : {NOUT{1'b0}};
  wire [NOUT-1:0] off_bits = (wr_fire & hit_scoff) ?
    wmask[pmcx_pkg::PMCX_SC_PCK_LSB +: NOUT] : {NOUT{1'b0}};
  wire [NOUT-1:0] next_pck_on = (pck_on | on_bits) & ~off_bits;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pck_on <= {NOUT{1'b0}};
    end else begin
      pck_on <= next_pck_on;
    end
  end

  for (genvar i = 0; i < NOUT; i++) begin : g_pck
    wire cfg_wr = wr_fire & hit_pck[i];
    wire [4:0] cfg_new = 5'(merge(32'(pck_cfg[i])));
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        pck_cfg[i] <= pmcx_pkg::PMCX_CFG_RST;
        pck_settled[i] <= 1'b0;
      end else begin
        if (cfg_wr) pck_cfg[i] <= cfg_new;
        // Follows the next enable, so ready never outlives a disable
        pck_settled[i] <= div_if[i].settled & next_pck_on[i] & ~cfg_wr;
      end
    end
    // A live rewrite restarts the divider unguarded
    assign div_if[i].restart = cfg_wr;
    assign div_if[i].sel = pck_cfg[i][pmcx_pkg::PMCX_CSS_LSB +: 2];
    assign div_if[i].ratio = pck_cfg[i][pmcx_pkg::PMCX_POWER_OF_TWO_RATIO_LSB +: 3];
    assign div_if[i].run = pck_on[i];
    assign prog_clock_out[i] = div_if[i].clk_out;
    pmcx_prescaler #(.CW(6)) u_pck_div (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .src_level(src_level),
      .src_rise(src_rise),
      .div(div_if[i])
    );
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_pll_zero_load;
    pll_wr && pll_new[pmcx_pkg::PMCX_PLL_CNT_LSB +: 6] == 6'h00;
  endsequence
  sequence s_quiet_lock;
    !pll_lock ##1 (pll_lock || pll_wr);
  endsequence

  a_on_strobe_sets: assert property (
    wr_fire && hit_scon && !hit_scoff && wmask[pmcx_pkg::PMCX_SC_PCK_LSB] |=> pck_on[0])
    else $error("enable strobe ignored");
  a_off_strobe_clears: assert property (
    wr_fire && hit_scoff && wmask[pmcx_pkg::PMCX_SC_PCK_LSB + 1] |=> !pck_on[1])
    else $error("disable strobe ignored");
  a_state_readback: assert property (
    $rose(wb_ack_o) && !wb_we_i && hit_scst |->
    wb_dat_o[pmcx_pkg::PMCX_SC_PCK_LSB +: NOUT] == $past(pck_on))
    else $error("state readback wrong");
  a_ready_needs_on: assert property (
    (pck_settled & ~pck_on) == {NOUT{1'b0}})
    else $error("ready on disabled output");
  a_off_after_reset: assert property (
    @(posedge clk_sys) disable iff (1'b0) $past(sys_rst) |-> pck_on == {NOUT{1'b0}})
    else $error("output enabled after reset");
  a_stable_at_zero: assert property (
    $rose(osc_stable) |-> osc_cnt == 11'h000 && $past(osc_enable))
    else $error("stable before count expired");
  a_meas_close: assert property (
    $rose(meas_done) |-> $past(slow_fall) && $past(fall_cnt) == pmcx_pkg::PMCX_MEAS_LAST_FALL)
    else $error("measure closed off the 16th fall");
  a_pll_unlock: assert property (
    pll_wr |=> !pll_lock)
    else $error("lock kept over rewrite");
  a_pll_zero_lock: assert property (
    s_pll_zero_load |=> s_quiet_lock)
    else $error("zero count lock late");
  a_mck_fallback: assert property (
    pll_hold |-> mck_sel == pmcx_pkg::PMCX_SRC_MAIN ##1 !master_settled)
    else $error("master not on main while unlocked");
  a_mck_wr_clear: assert property (
    mck_wr |=> !master_settled)
    else $error("master ready kept over rewrite");
endmodule

// File: bench/pmcx_clk_partner.sv
`timescale 1ns/100ps
// ********************************
// Clock sources and output watcher
// ********************************
module pmcx_clk_partner (
  input wire logic clk_sys,
  input wire logic osc_enable,
  input wire logic pll_enable,
  input wire logic [3:0] watch,
  output logic slow_clock,
  output logic main_clock,
  output logic pll_clock,
  output int period [4],
  output int rises [4]
);
  int cnt;
  int last [4];
  logic [3:0] watch_q;
  // Known start so the first samples are defined
  initial begin
    slow_clock = 1'b0;
    main_clock = 1'b0;
    pll_clock = 1'b0;
    cnt = 0;
    watch_q = 4'h0;
    period = '{default: 0};
    rises = '{default: 0};
    last = '{default: 0};
  end
  // Sources stay far below clk_sys/2; main and PLL are dead while not enabled
  always @(posedge clk_sys) begin
    cnt <= cnt + 1;
    if (cnt % 16 == 15) begin
      slow_clock <= ~slow_clock; // Period 32 cycles
    end
    main_clock <= osc_enable ? (cnt % 4 < 2) : 1'b0; // Period 4
    pll_clock <= pll_enable ? (cnt % 6 < 3) : 1'b0; // Period 6
    watch_q <= watch;
    // Rise-to-rise spacing of each watched output, in clk_sys cycles
    for (int i = 0; i < 4; i++) begin
      if (watch[i] && !watch_q[i]) begin
        period[i] <= cnt - last[i];
        last[i] <= cnt;
        rises[i] <= rises[i] + 1;
      end
    end
  end
endmodule

// File: bench/pmc_clock_setup_and_outputs_tb_top.sv
`timescale 1ns/100ps
module pmc_clock_setup_and_outputs_tb_top;
  logic clk_sys, sys_rst, cyc, stb, we, wack, mck, osc_en, pll_en, slow, mainc, pllc;
  logic [7:0] adr, pdiv;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [2:0] pck;
  logic [10:0] pfac;
  logic [1:0] prng;
  int period [4];
  int rises [4];
  int mismatches, num_checks, tick, el, r0;

  pmcx_top #(.NOUT(3), .TALLY_W(16)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(wack), .slow_clock(slow),
    .main_clock(mainc), .pll_clock(pllc), .prog_clock_out(pck), .master_clk_out(mck),
    .osc_enable(osc_en), .pll_divider(pdiv), .pll_factor(pfac), .pll_range(prng),
    .pll_enable(pll_en));
  pmcx_clk_partner i_partner (.clk_sys(clk_sys), .osc_enable(osc_en), .pll_enable(pll_en),
    .watch({mck, pck}), .slow_clock(slow), .main_clock(mainc), .pll_clock(pllc),
    .period(period), .rises(rises));

  // ********************************
  // Clock and helpers
  // ********************************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) tick <= tick + 1;

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic cycle: hold until ack is sampled, take data there, then release
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      complete_run();
    end
  endtask
  // Poll a flag with a cycle bound; el keeps the elapsed cycles
  task poll(input logic [7:0] a, input int b, input int lim);
    int s;
    s = tick;
    do wb(1'b0, a, 32'h0); while (q[b] !== 1'b1 && tick - s < lim);
    el = tick - s;
    if (q[b] !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask
  task hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Safe reprogramming: off, configure, on, wait ready, then measure
  task set_out(input int i, input logic [1:0] src, input logic [2:0] r, input int exp);
    logic [7:0] a;
    a = pmcx_pkg::PMCX_OFS_PCK0 + 8'(4 * i);
    wb(1'b1, pmcx_pkg::PMCX_OFS_SCOFF, 32'h100 << i);
    wb(1'b1, a, {27'h0, r, src});
    wb(1'b0, pmcx_pkg::PMCX_OFS_SR, 32'h0);
    chk(32'(q[8 + i]), 32'h0);
    wb(1'b1, pmcx_pkg::PMCX_OFS_SCON, 32'h100 << i);
    poll(pmcx_pkg::PMCX_OFS_SR, 8 + i, 2000);
    hold(3 * exp + 4);
    chk(32'(period[i]), 32'(exp));
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    sys_rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    tick = 0;
    mismatches = 0;
    num_checks = 0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Reset state, plus an unmapped place
    wb(1'b0, pmcx_pkg::PMCX_OFS_SCSTATE, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, pmcx_pkg::PMCX_OFS_PLL, 32'h0);
    chk(q, pmcx_pkg::PMCX_PLL_RST);
    wb(1'b0, pmcx_pkg::PMCX_OFS_MCK, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h7C, 32'h0);
    chk(q, 32'h0);
    hold(100);
    chk(32'(period[3]), 32'd32);
    // Start-up: count 2 means 16 slow cycles of 32
    wb(1'b1, pmcx_pkg::PMCX_OFS_OSC, 32'h0000_0201);
    poll(pmcx_pkg::PMCX_OFS_SR, 0, 1500);
    chk(32'(el >= 480 && el <= 524), 32'h1);
    poll(pmcx_pkg::PMCX_OFS_FREQ, 16, 1500);
    chk(32'(q[15:0] >= 16'd123 && q[15:0] <= 16'd129), 32'h1);
    // Every ratio code on output 0; code 7 acts as 6
    for (int r = 0; r < 8; r++) begin
      set_out(0, pmcx_pkg::PMCX_SRC_MAIN, 3'(r), 4 << (r > 6 ? 6 : r));
    end
    set_out(1, pmcx_pkg::PMCX_SRC_SLOW, 3'h1, 64);
    // PLL lock after four slow cycles, range field at 1
    wb(1'b1, pmcx_pkg::PMCX_OFS_PLL, 32'h0004_4401);
    wb(1'b0, pmcx_pkg::PMCX_OFS_SR, 32'h0);
    chk(32'(q[2]), 32'h0);
    poll(pmcx_pkg::PMCX_OFS_SR, 2, 1000);
    chk(32'(el >= 96 && el <= 140), 32'h1);
    chk({11'h0, prng, pfac, pdiv}, {11'h0, 2'h1, 11'h4, 8'h1});
    chk(32'(pll_en), 32'h1);
    set_out(2, pmcx_pkg::PMCX_SRC_PLL, 3'h1, 12);
    wb(1'b0, pmcx_pkg::PMCX_OFS_SCSTATE, 32'h0);
    chk(q, 32'h700);
    wb(1'b1, pmcx_pkg::PMCX_OFS_SCOFF, 32'h200);
    wb(1'b0, pmcx_pkg::PMCX_OFS_SCSTATE, 32'h0);
    chk(q, 32'h500);
    r0 = rises[1];
    hold(200);
    chk(32'(rises[1]), 32'(r0));
    // Master clock: main over 16, then PLL, then a PLL rewrite
    wb(1'b1, pmcx_pkg::PMCX_OFS_MCK, 32'h11);
    poll(pmcx_pkg::PMCX_OFS_SR, 3, 1000);
    hold(200);
    chk(32'(period[3]), 32'd64);
    wb(1'b1, pmcx_pkg::PMCX_OFS_MCK, 32'h03);
    poll(pmcx_pkg::PMCX_OFS_SR, 3, 1000);
    hold(30);
    chk(32'(period[3]), 32'd6);
    wb(1'b1, pmcx_pkg::PMCX_OFS_PLL, 32'h0004_0401);
    wb(1'b0, pmcx_pkg::PMCX_OFS_SR, 32'h0);
    chk(q & 32'hC, 32'h0);
    hold(20);
    chk(32'(period[3]), 32'd4);
    poll(pmcx_pkg::PMCX_OFS_SR, 3, 1000);
    chk(32'(q[2]), 32'h1);
    hold(30);
    chk(32'(period[3]), 32'd6);
    // Either field at zero switches the PLL off
    wb(1'b1, pmcx_pkg::PMCX_OFS_PLL, 32'h0004_0400);
    hold(2);
    chk(32'(pll_en), 32'h0);
    wb(1'b1, pmcx_pkg::PMCX_OFS_PLL, 32'h0000_0401);
    hold(2);
    chk(32'(pll_en), 32'h0);
    // A zero lock count sets lock right after the write
    wb(1'b1, pmcx_pkg::PMCX_OFS_PLL, 32'h0004_0001);
    wb(1'b0, pmcx_pkg::PMCX_OFS_SR, 32'h0);
    chk(32'(q[2]), 32'h1);
    complete_run();
  end
endmodule
